//--- logic/ebs_defs.svh
// offsets, field positions and reset values of the bus cycle sequencer
`ifndef EBS_DEFS_SVH
`define EBS_DEFS_SVH
`define EBS_TIMING0_OFS 12'h000
`define EBS_TIMING1_OFS 12'h004
`define EBS_CTRL_OFS 12'h008
`define EBS_REQ_OFS 12'h00C
`define EBS_STATUS_OFS 12'h010
`define EBS_RDATA_OFS 12'h014
`define EBS_AB_POS 0
`define EBS_XAB_POS 1
`define EBS_C_POS 3
`define EBS_D_POS 5
`define EBS_E_POS 6
`define EBS_F_POS 11
`define EBS_MUX_POS 13
`define EBS_TIMING_RST 32'h0000_0000
`define EBS_REQ_WR_POS 24
`define EBS_REQ_WIN_POS 25
`define EBS_REQ_BYTE_POS 26
`endif

//--- logic/ebs_pkg.sv
// types shared by the bus cycle sequencer
package ebs_pkg;
  typedef enum logic [2:0] {
    EBS_IDLE = 3'h0,
    EBS_SETUP = 3'h1,
    EBS_CMD = 3'h3,
    EBS_DSET = 3'h2,
    EBS_ACC = 3'h6,
    EBS_HOLD = 3'h7
  } ebs_phase_e;
  typedef logic [13:0] ebs_timing_t;
endpackage

//--- logic/ebs_sequencer.sv
// external bus cycle sequencer with apb register access
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "ebs_defs.svh"
module ebs_sequencer
  import ebs_pkg::*;
(
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // external bus
  output logic [15:0] bus_addr,
  output logic [15:0] bus_dout,
  output logic bus_doe_n,
  input wire logic [15:0] bus_din,
  output logic addr_latch,
  output logic rd_n,
  output logic wr_n,
  output logic cs_n,
  output logic upper_byte_select_n,
  output logic bus_reference_clock
);
  import ebs_pkg::*;

  ////////////////////////////////////////////////////////////////
  // registers
  ebs_timing_t bus_phase_timing_ctrl0;
  ebs_timing_t bus_phase_timing_ctrl1;
  logic [15:0] rdata;
  logic [15:0] req_addr;
  logic [15:0] req_wdata;
  logic req_wr;
  logic req_win;
  logic req_byte;
  logic busy;
  logic last_win;
  logic pend;
  ebs_phase_e phase;
  logic [4:0] cnt;

  // apb decode; every access completes in its first access cycle
  wire apb_go = psel & penable & clk_en;
  wire apb_wr = apb_go & pwrite;
  wire sel_t0 = paddr == `EBS_TIMING0_OFS;
  wire sel_t1 = paddr == `EBS_TIMING1_OFS;
  wire sel_req = paddr == `EBS_REQ_OFS;
  wire sel_st = paddr == `EBS_STATUS_OFS;
  wire sel_rd = paddr == `EBS_RDATA_OFS;
  wire mapped = sel_t0 | sel_t1 | sel_req | sel_st | sel_rd;
  // a request written while busy is refused with an error; the access edge
  // obeys the verdict given at setup, so a cycle ending in between cannot
  // accept a request that was already answered with an error
  wire req_take = apb_wr & sel_req & ~pslverr;
  wire [31:0] rd_mux = sel_t0 ? {18'h0, bus_phase_timing_ctrl0} :
                       sel_t1 ? {18'h0, bus_phase_timing_ctrl1} :
                       sel_st ? {31'h0, busy | pend} :
                       sel_rd ? {16'h0, rdata} : 32'h0;

  // timing setting of the window being served
  wire ebs_timing_t tsel = req_win ? bus_phase_timing_ctrl1 : bus_phase_timing_ctrl0;
  wire shared_addr_data_mode = tsel[`EBS_MUX_POS];
  wire [4:0] len_ab = {4'h0, tsel[`EBS_AB_POS]} + 5'h1
                      + ((req_win != last_win) ? {3'h0, tsel[`EBS_XAB_POS+:2]} : 5'h0);
  wire [4:0] len_c = {3'h0, tsel[`EBS_C_POS+:2]};
  wire [4:0] len_d = {4'h0, tsel[`EBS_D_POS]};
  wire [4:0] len_e = tsel[`EBS_E_POS+:5]; // access length minus one
  wire [4:0] len_f = {3'h0, tsel[`EBS_F_POS+:2]};
  wire phase_end = cnt == 5'h0;

  // next phase: zero-length phases are skipped in fixed order
  ebs_phase_e next_phase;
  logic [4:0] next_cnt;
  always_comb begin
    next_phase = phase;
    next_cnt = cnt - 5'h1;
    unique case (phase)
      EBS_IDLE: begin
        next_cnt = cnt;
        if (pend) begin
          next_phase = EBS_SETUP;
          next_cnt = len_ab - 5'h1;
        end
      end
      EBS_SETUP, EBS_CMD, EBS_DSET: begin
        if (phase_end) begin
          if (phase == EBS_SETUP && len_c != 5'h0) begin
            next_phase = EBS_CMD;
            next_cnt = len_c - 5'h1;
          end else if (phase != EBS_DSET && len_d != 5'h0) begin
            next_phase = EBS_DSET;
            next_cnt = 5'h0;
          end else begin
            next_phase = EBS_ACC;
            next_cnt = len_e;
          end
        end
      end
      EBS_ACC: begin
        if (phase_end) begin
          next_phase = (len_f != 5'h0) ? EBS_HOLD : EBS_IDLE;
          next_cnt = len_f - 5'h1;
        end
      end
      EBS_HOLD: begin
        if (phase_end) begin
          next_phase = EBS_IDLE;
          next_cnt = 5'h0;
        end
      end
      default: begin
        next_phase = EBS_IDLE;
        next_cnt = 5'h0;
      end
    endcase
  end

  wire acc_end = phase == EBS_ACC && phase_end;
  wire in_cycle = phase != EBS_IDLE;
  wire next_strobe = next_phase == EBS_ACC;
  wire next_drive = req_wr & (next_phase != EBS_IDLE) &
                    ~(shared_addr_data_mode & next_phase == EBS_SETUP);

  ////////////////////////////////////////////////////////////////
  // apb registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_phase_timing_ctrl0 <= 14'h0000;
      bus_phase_timing_ctrl1 <= 14'h0000;
      req_addr <= 16'h0000;
      req_wdata <= 16'h0000;
      req_wr <= 1'b0;
      req_win <= 1'b0;
      req_byte <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & (~mapped | (pwrite & sel_req & (busy | pend)));
      prdata <= rd_mux;
      if (apb_wr & sel_t0) bus_phase_timing_ctrl0 <= pwdata[13:0];
      if (apb_wr & sel_t1) bus_phase_timing_ctrl1 <= pwdata[13:0];
      if (req_take) begin
        req_addr <= pwdata[15:0];
        req_wdata <= pwdata[23:16] == 8'h0 ? req_wdata : {pwdata[23:16], pwdata[23:16]};
        req_wr <= pwdata[`EBS_REQ_WR_POS];
        req_win <= pwdata[`EBS_REQ_WIN_POS];
        req_byte <= pwdata[`EBS_REQ_BYTE_POS];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // phase sequencer and read capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= EBS_IDLE;
      cnt <= 5'h0;
      pend <= 1'b0;
      busy <= 1'b0;
      last_win <= 1'b0;
      rdata <= 16'h0000;
    end else if (clk_en) begin
      phase <= next_phase;
      cnt <= next_cnt;
      pend <= req_take | (pend & phase != EBS_IDLE);
      if (phase == EBS_IDLE && pend) begin
        busy <= 1'b1;
        last_win <= req_win;
      end else if (in_cycle && next_phase == EBS_IDLE) busy <= 1'b0;
      // same edge that raises the strobe; memory holds data till then
      // the data meet a setup time to this edge of our own clock, so no
      // synchroniser: one would hand back stale data on short accesses
      if (acc_end & ~req_wr) rdata <= bus_din;
    end
  end

  ////////////////////////////////////////////////////////////////
  // bus pins, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_addr <= 16'h0000;
      bus_dout <= 16'h0000;
      bus_doe_n <= 1'b1;
      addr_latch <= 1'b0;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      cs_n <= 1'b1;
      upper_byte_select_n <= 1'b1;
      bus_reference_clock <= 1'b0;
    end else if (clk_en) begin
      bus_reference_clock <= ~bus_reference_clock;
      cs_n <= next_phase == EBS_IDLE;
      addr_latch <= shared_addr_data_mode & next_phase == EBS_SETUP;
      bus_addr <= next_phase != EBS_IDLE ? req_addr : bus_addr;
      upper_byte_select_n <= next_phase == EBS_IDLE ? 1'b1 : req_byte;
      rd_n <= ~(next_strobe & ~req_wr);
      wr_n <= ~(next_strobe & req_wr);
      // shared mode puts the address on data lines in setup
      bus_dout <= (shared_addr_data_mode & next_phase == EBS_SETUP) ? req_addr : req_wdata;
      bus_doe_n <= ~(next_drive | (shared_addr_data_mode & next_phase == EBS_SETUP));
    end
  end

  ////////////////////////////////////////////////////////////////
  // assertions
  strobe_in_acc_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!rd_n || !wr_n) |-> $past(phase) == EBS_ACC || phase == EBS_ACC)
    else $error("strobe outside access");
  hold_no_strobe_a: assert property (@(posedge pclk) disable iff (!presetn)
    phase == EBS_HOLD && $past(phase) == EBS_HOLD |-> rd_n && wr_n)
    else $error("strobe in hold");
  order_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && phase == EBS_ACC && next_phase != EBS_ACC |-> next_phase inside {EBS_HOLD, EBS_IDLE})
    else $error("bad order after access");
  setup_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    phase == EBS_IDLE && next_phase == EBS_SETUP |-> len_ab >= 5'h1 && len_ab <= 5'h5)
    else $error("setup length out of range");
  win_change_a: assert property (@(posedge pclk) disable iff (!presetn)
    phase == EBS_IDLE && pend && req_win == last_win |-> len_ab == {4'h0, tsel[`EBS_AB_POS]} + 5'h1)
    else $error("extension without window change");
  dset_one_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && phase == EBS_DSET |=> phase != EBS_DSET)
    else $error("data setup longer than one");
  wr_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_n |-> !bus_doe_n && bus_dout == req_wdata)
    else $error("write data not driven");
  rd_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && acc_end && !req_wr |=> rdata == $past(bus_din) && rd_n)
    else $error("read capture wrong");
  timing_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    in_cycle |-> $stable(req_win) && $stable(req_addr) && $stable(req_wr))
    else $error("window or request changed inside a cycle");
  read_c: cover property (@(posedge pclk) disable iff (!presetn) acc_end && !req_wr);
  write_c: cover property (@(posedge pclk) disable iff (!presetn) acc_end && req_wr);
  hold_c: cover property (@(posedge pclk) disable iff (!presetn) phase == EBS_HOLD);
  ext_c: cover property (@(posedge pclk) disable iff (!presetn) phase == EBS_IDLE && pend && req_win != last_win);
endmodule
`default_nettype wire

//--- verif/ebs_mem_model.sv
// behavioural memory on the external bus of the cycle sequencer
`timescale 1ns/1ns
`default_nettype none
module ebs_mem_model (
  // clock
  input wire logic pclk,
  // external bus
  input wire logic [15:0] bus_addr,
  input wire logic [15:0] bus_dout,
  input wire logic addr_latch,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic cs_n,
  input wire logic bus_doe_n,
  input wire logic upper_byte_select_n,
  output logic [15:0] bus_din,
  // figures of the last finished cycle
  output var logic [7:0] cyc_len = 8'h00,
  output var logic [7:0] acc_len = 8'h00,
  output var logic ale_seen = 1'b0,
  output var logic [7:0] drv_len = 8'h00,
  output var logic byte_n = 1'b1,
  output var logic [15:0] wr_data = 16'h0000
);
  logic [7:0] cyc = 8'h00;
  logic [7:0] acc = 8'h00;
  logic ale = 1'b0;
  logic [7:0] drv = 8'h00;
  logic bsel = 1'b1;
  logic [15:0] last = 16'h0000;
  // data held while the strobe is low; a released bus shows the inverse so stale data never matches
  assign bus_din = !rd_n ? (bus_addr ^ 16'h5A3C) : ~last;
  ////////////////////////////////////////////////////////////////////////////////
  // count the clocks of each cycle and publish them when chip select rises
  always @(posedge pclk) begin
    if (!rd_n) last <= bus_din;
    if (!wr_n) wr_data <= bus_dout;
    if (!cs_n) begin
      cyc <= cyc + 8'h01;
      acc <= acc + {7'h00, !rd_n || !wr_n};
      ale <= ale | addr_latch;
      drv <= drv + {7'h00, !bus_doe_n && (!rd_n || !wr_n)};
      bsel <= upper_byte_select_n;
    end else if (cyc != 8'h00) begin
      cyc_len <= cyc;
      acc_len <= acc;
      ale_seen <= ale;
      drv_len <= drv;
      byte_n <= bsel;
      drv <= 8'h00;
      cyc <= 8'h00;
      acc <= 8'h00;
      ale <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- verif/testbench.sv
// self-checking bench for the external bus cycle sequencer
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, r;
  logic pready, pslverr, e, addr_latch, rd_n, wr_n, cs_n, ale_seen;
  logic bus_doe_n, upper_byte_select_n, bus_reference_clock, byte_n, ref_q;
  logic prev_win = 1'b0;
  logic [15:0] bus_addr, bus_dout, bus_din, wr_data;
  logic [7:0] cyc_len, acc_len, drv_len;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;

  always #5 pclk = ~pclk;

  ebs_sequencer i_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_addr(bus_addr), .bus_dout(bus_dout), .bus_doe_n(bus_doe_n), .bus_din(bus_din), .addr_latch(addr_latch),
    .rd_n(rd_n), .wr_n(wr_n), .cs_n(cs_n), .upper_byte_select_n(upper_byte_select_n),
    .bus_reference_clock(bus_reference_clock));
  ebs_mem_model i_mem (.pclk(pclk), .bus_addr(bus_addr), .bus_dout(bus_dout), .addr_latch(addr_latch),
    .rd_n(rd_n), .wr_n(wr_n), .cs_n(cs_n), .bus_doe_n(bus_doe_n), .upper_byte_select_n(upper_byte_select_n),
    .bus_din(bus_din), .cyc_len(cyc_len), .acc_len(acc_len), .ale_seen(ale_seen), .drv_len(drv_len),
    .byte_n(byte_n), .wr_data(wr_data));

  ////////////////////////////////////////////////////////////////////////////////
  // verdict and the end of the run
  task end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      mismatches++;
      $display("unexpected at %0t: got %h, want %h", $time, g, x);
    end
  endtask

  // one apb transfer, held until pready is seen at an edge
  // no cycle count is assumed here: only the bench timeout ends a wait
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // program a window, run one cycle, wait for idle, then check its shape
  task run(input logic [13:0] t, input logic w, input logic wr, input logic [15:0] a, input logic [7:0] b);
    int x;
    apb(1'b1, w ? 12'h004 : 12'h000, {18'h00000, t});
    apb(1'b1, 12'h00C, {5'h00, a[0], w, wr, b, a});
    chk(e, 1'b0);
    do begin
      apb(1'b0, 12'h010, 32'h0000_0000);
    end while (r[0] !== 1'b0);
    repeat (2) @(posedge pclk);
    x = t[0] + (w != prev_win ? t[2:1] : 0) + t[4:3] + t[5] + t[10:6] + t[12:11] + 2;
    chk(cyc_len, x);
    chk(acc_len, t[10:6] + 1);
    chk(ale_seen, t[13]);
    chk(drv_len, wr ? t[10:6] + 1 : 0);
    chk(byte_n, a[0]);
    if (wr) chk(wr_data, {b, b});
    else begin
      apb(1'b0, 12'h014, 32'h0000_0000);
      chk(r[15:0], a ^ 16'h5A3C);
    end
    prev_win = w;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence: reset values, unmapped access, both modes and windows, refusal while busy
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk(r, 32'h0000_0000);
    apb(1'b0, 12'h018, 32'h0000_0000);
    chk(e, 1'b1);
    // the reference clock flips on every enabled edge
    ref_q = bus_reference_clock;
    @(posedge pclk);
    chk(bus_reference_clock, !ref_q);
    run(14'h00C0, 1'b0, 1'b0, 16'h1234, 8'h11);
    run(14'h1FFF, 1'b1, 1'b1, 16'hBEEF, 8'hA5);
    run(14'h2148, 1'b1, 1'b0, 16'h0F0F, 8'h22);
    run(14'h2804, 1'b0, 1'b1, 16'h8001, 8'h3C);
    // a long access keeps the sequencer busy, so a second request is refused
    apb(1'b1, 12'h000, 32'h0000_07C0);
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk(r, 32'h0000_07C0);
    apb(1'b1, 12'h00C, 32'h0000_1111);
    apb(1'b1, 12'h00C, 32'h0000_2222);
    chk(e, 1'b1);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk(r[0], 1'b1);
    end_of_test;
  end

  // cut a hang short
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test;
    end
  end
endmodule
`default_nettype wire
